// ---- design/dmdc_map.svh ----
// Constants for the dual modulus divider control block.
`ifndef DMDC_MAP_SVH
`define DMDC_MAP_SVH
`define DMDC_LOW_MODULUS     5'h14
`define DMDC_HIGH_MODULUS    5'h15
`define DMDC_CHANNELS        6'h17
`define DMDC_CHAN_CAPACITY   6'h28
`define DMDC_RX_OFFSET       13'h085C
`define DMDC_TERMINAL_STATE  9'h001
`define DMDC_RESET_COARSE    9'h10D
`define DMDC_RESET_FINE      5'h0D
`endif

// ---- design/dmdc_pkg.sv ----
// Types shared by the dual modulus divider control block.
package dmdc_pkg;
  typedef logic [8:0] dmdc_coarse_t;
  typedef logic [4:0] dmdc_fine_t;
  typedef struct packed {
    dmdc_coarse_t coarse;
    dmdc_fine_t   fine;
  } dmdc_counts_t;
  typedef struct packed {
    logic       rx_mode;
    logic [5:0] channel;
  } dmdc_select_t;
endpackage

// ---- design/dmdc_divider.sv ----
// Channel memory and dual modulus divide control for the synthesizer loop.
// Summary of operation
// - Total ratio is twenty coarse plus fine.
// - At fine plus one select divide-by-21.
// - Decode terminal state one toward load stage.
// - Next edge drops load, presets coarse count.
// - Same edge returns prescaler to divide-by-20.
// - Transmit mode gives coarse/fine per channel.
// - Receive mode gives separate coarse/fine pairs.
// - Twenty-three channels, room for forty.
`timescale 1ns/1ps
`include "dmdc_map.svh"
module dmdc_divider (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Prescaler output pulse, from the VCO domain pin.
  input  wire logic                 presc_pulse_pin,
  // Channel and mode selection from the keyboard interface.
  input  wire dmdc_pkg::dmdc_select_t sel,
  // Prescaler modulus control, high selects divide-by-21.
  output logic                      modulus_high,
  // Load strobe, active low.
  output logic                      load_n,
  // Current count pair, for observation.
  output dmdc_pkg::dmdc_counts_t    counts
);

  logic                   sync1_reg;   // First synchroniser stage.
  logic                   sync2_reg;   // Second synchroniser stage.
  logic                   sync3_reg;   // Edge history.
  logic                   step;        // One prescaler pulse seen.
  dmdc_pkg::dmdc_coarse_t count_reg;   // Down-counter.
  dmdc_pkg::dmdc_counts_t lut;         // Channel memory output.
  logic                   mod_decode;  // Fine plus one reached.
  logic                   term_decode; // Terminal state reached.
  logic [4:0]             wide_cnt_reg; // Divide-by-21 intervals seen in this cycle.
  logic                   clean_reg;    // Cycle began at a preset and the selection held.
  dmdc_pkg::dmdc_select_t sel_load_reg; // Selection in force at the last preset.

  // Channel memory. Ratio increments follow the channel plan; unused codes give channel one,
  // and codes 24..40 are left free for later channels.
  function automatic dmdc_pkg::dmdc_counts_t chan_lookup(input dmdc_pkg::dmdc_select_t s);
    logic [12:0]            ratio; // Total division ratio for the selection.
    dmdc_pkg::dmdc_counts_t split; // Coarse and fine parts of that ratio.
    ratio = 13'h0000;
    split = '0;
    unique case (s.channel)
      6'h01: ratio = 13'h1511;
      6'h02: ratio = 13'h1513;
      6'h03: ratio = 13'h1515;
      6'h04: ratio = 13'h1519;
      6'h05: ratio = 13'h151B;
      6'h06: ratio = 13'h151D;
      6'h07: ratio = 13'h151F;
      6'h08: ratio = 13'h1523;
      6'h09: ratio = 13'h1525;
      6'h0A: ratio = 13'h1527;
      6'h0B: ratio = 13'h1529;
      6'h0C: ratio = 13'h152D;
      6'h0D: ratio = 13'h152F;
      6'h0E: ratio = 13'h1531;
      6'h0F: ratio = 13'h1533;
      6'h10: ratio = 13'h1537;
      6'h11: ratio = 13'h1539;
      6'h12: ratio = 13'h153B;
      6'h13: ratio = 13'h153D;
      6'h14: ratio = 13'h1541;
      6'h15: ratio = 13'h1543;
      6'h16: ratio = 13'h1545;
      6'h17: ratio = 13'h154B;
      default: ratio = 13'h1511;
    endcase
    // Receive ratios sit a fixed 2140 below transmit, the IF offset over the step size.
    if (s.rx_mode) begin
      ratio = ratio - `DMDC_RX_OFFSET;
    end
    // Split into coarse and fine so that ratio = 20*coarse + fine. The fine part stays below
    // twenty, which keeps the divide-by-21 stretch inside a single division cycle.
    split.coarse = 9'(ratio / 13'(`DMDC_LOW_MODULUS));
    split.fine   = 5'(ratio % 13'(`DMDC_LOW_MODULUS));
    return split;
  endfunction

  assign lut         = chan_lookup(sel);
  assign mod_decode  = (count_reg == 9'(lut.fine) + 9'h001);
  assign term_decode = (count_reg == `DMDC_TERMINAL_STATE);
  assign step        = sync2_reg & ~sync3_reg;

  // Synchronise the prescaler pulse; stage one feeds no logic, stages two and three feed the edge detect.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= presc_pulse_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Load stage: a D stage fed by the terminal decode, clocked by prescaler pulses.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_n <= 1'b1;
    end else if (step) begin
      load_n <= ~term_decode;
    end
  end

  // Down-counter, one step per prescaler pulse. The step that sees state one presets the coarse
  // count on the same edge that drops the load strobe. Presetting one step later would add a
  // state, so every cycle would run twenty oscillator periods too long.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= `DMDC_RESET_COARSE;
    end else if (step) begin
      if (term_decode) begin
        count_reg <= lut.coarse;
      end else if (count_reg != 9'h000) begin
        count_reg <= count_reg - 9'h001;
      end
    end
  end

  // Modulus latch: set to 21 at fine plus one, back to 20 on the loading edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modulus_high <= 1'b0;
    end else if (step) begin
      if (term_decode) begin
        modulus_high <= 1'b0;
      end else if (mod_decode) begin
        modulus_high <= 1'b1;
      end
    end
  end

  // Registered copy of the current count pair.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counts <= {`DMDC_RESET_COARSE, `DMDC_RESET_FINE};
    end else begin
      counts <= lut;
    end
  end

  // Checker helper: counts the pulse intervals spent at divide-by-21 since the last preset. The
  // terminal step itself is left out, so the check adds the latch value that it sees there.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wide_cnt_reg <= 5'h00;
    end else if (step) begin
      if (term_decode) begin
        wide_cnt_reg <= 5'h00;
      end else if (modulus_high) begin
        wide_cnt_reg <= wide_cnt_reg + 5'h01;
      end
    end
  end

  // Checker helper: a cycle only counts as clean when it began at a preset and the selection
  // has not moved since; after reset or a channel change the first cycle is a mixture.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clean_reg    <= 1'b0;
      sel_load_reg <= '0;
    end else if (step && term_decode) begin
      clean_reg    <= 1'b1;
      sel_load_reg <= sel;
    end else if (sel != sel_load_reg) begin
      clean_reg <= 1'b0;
    end
  end

  // The pulse step at which the counter stands in state one.
  sequence s_term_step;
    step && term_decode;
  endsequence

  // The step that closes the cycle drops the load strobe.
  property p_load_follows_term;
    @(posedge clk) disable iff (rst) s_term_step |=> !load_n;
  endproperty
  a_load_follows_term: assert property (p_load_follows_term) else $error("load not asserted");

  // The load strobe stands low for one pulse interval only.
  property p_load_release;
    @(posedge clk) disable iff (rst) (step && !load_n) |=> load_n;
  endproperty
  a_load_release: assert property (p_load_release) else $error("load held too long");

  // The same closing step returns the prescaler to divide-by-20.
  property p_mod_back20;
    @(posedge clk) disable iff (rst) s_term_step |=> !modulus_high;
  endproperty
  a_mod_back20: assert property (p_mod_back20) else $error("modulus not reset");

  // Reaching fine plus one switches the prescaler to divide-by-21.
  property p_mod_21;
    @(posedge clk) disable iff (rst) (step && mod_decode && !term_decode) |=> modulus_high;
  endproperty
  a_mod_21: assert property (p_mod_21) else $error("modulus not set");

  // The closing step presets the counter to the coarse count of the selection.
  property p_preset;
    @(posedge clk) disable iff (rst) s_term_step |=> count_reg == $past(lut.coarse);
  endproperty
  a_preset: assert property (p_preset) else $error("preset wrong");

  // Every other pulse step with the count above zero takes exactly one off the count.
  property p_dec;
    @(posedge clk) disable iff (rst)
      (step && !term_decode && count_reg != 9'h000) |=> count_reg == $past(count_reg) - 9'h001;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");

  // Without a pulse the count must not move.
  property p_hold;
    @(posedge clk) disable iff (rst) !step |=> $stable(count_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without pulse");

  // Over a clean cycle of coarse pulses the divide-by-21 intervals number exactly the fine count,
  // which makes the loop ratio twenty coarse plus fine.
  property p_ratio;
    @(posedge clk) disable iff (rst)
      s_term_step ##0 (clean_reg && sel == sel_load_reg) |->
        (wide_cnt_reg + 5'(modulus_high) == lut.fine) && (lut.fine < 5'h14);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio split wrong");

  // Channel one carries a known pair in both modes.
  property p_ch1;
    @(posedge clk) disable iff (rst)
      (sel.channel == 6'h01) |-> (sel.rx_mode ? lut.coarse == 9'h0A2 : lut.coarse == 9'h10D) && lut.fine == 5'h0D;
  endproperty
  a_ch1: assert property (p_ch1) else $error("channel one pair wrong");

endmodule

// ---- tb/dmdc_presc_model.sv ----
// Behavioural 20/21 prescaler that paces the divider.
`timescale 1ns/1ps
module dmdc_presc_model (
  // Clock and reset.
  input  wire logic   clk,
  input  wire logic   rst,
  // Controls from the block.
  input  wire logic   modulus_high,
  input  wire logic   load_n,
  // Pulse output and measured loop ratio.
  output logic        presc_pulse_pin,
  output logic [15:0] ratio,
  output logic [7:0]  cycles
);
  logic [2:0]  ph;    // Phase of the six-cycle pulse.
  logic [15:0] acc;   // Oscillator cycles since the last load.
  logic        lp;    // Load strobe seen last cycle.
  // Pulses are three cycles high and three low, inside the sync limits.
  // Each pulse closes an interval of 20 or 21 oscillator cycles.
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      ph <= 3'h0;
      acc <= 16'h0;
      lp <= 1'b1;
      cycles <= 8'h0;
      ratio <= 16'h0;
      presc_pulse_pin <= 1'b0;
    end else begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      presc_pulse_pin <= (ph < 3'h3);
      lp <= load_n;
      if (lp && !load_n) begin
        ratio <= acc;
        acc <= 16'h0;
        cycles <= cycles + 8'h1;
      end else if (ph == 3'h0) begin
        acc <= acc + (modulus_high ? 16'h15 : 16'h14);
      end
    end
  end
endmodule

// ---- tb/test_dmdc_divider.sv ----
// Self-checking bench for the divider control block.
`timescale 1ns/1ps
module test_dmdc_divider;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   presc_pulse_pin;
  logic                   modulus_high;
  logic                   load_n;
  logic [15:0]            ratio;
  logic [7:0]             cycles;
  dmdc_pkg::dmdc_select_t sel = '0;
  dmdc_pkg::dmdc_counts_t counts;
  int                     fails = 0;
  int                     checks_done = 0;
  // A 40 MHz clock.
  always #12.5 clk = ~clk;
  dmdc_divider dmdc_divider_inst (.clk(clk), .rst(rst), .presc_pulse_pin(presc_pulse_pin), .sel(sel),
    .modulus_high(modulus_high), .load_n(load_n), .counts(counts));
  dmdc_presc_model dmdc_presc_model_inst (.clk(clk), .rst(rst), .modulus_high(modulus_high),
    .load_n(load_n), .presc_pulse_pin(presc_pulse_pin), .ratio(ratio), .cycles(cycles));
  // Prints the verdict and ends the run.
  task automatic summarize;
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Unknown channels fall back to channel one; receive is 107 coarse lower.
  function automatic dmdc_pkg::dmdc_counts_t exp_of(logic rx, int ch);
    int                     c;
    int                     i;
    dmdc_pkg::dmdc_counts_t r;
    c = (ch < 1 || ch > 23) ? 1 : ch;
    i = (c == 23) ? 4 : (c + 4) % 8;
    r.coarse = 9'(269 + (c > 3) + (c > 11) + (c > 19) - (rx ? 107 : 0));
    r.fine = 5'((i < 4) ? 2 * i + 1 : 2 * i + 3);
    return r;
  endfunction
  // Every channel in both modes, plus unmapped ones.
  task automatic t_table;
    for (int m = 0; m < 2; m++) begin
      for (int ch = 0; ch < 26; ch++) begin
        sel.rx_mode = m[0];
        sel.channel = 6'((ch == 25) ? 40 : ch);
        repeat (2) @(negedge clk);
        check("counts", counts, exp_of(m[0], sel.channel));
      end
    end
  endtask
  // Measures a full division cycle after the new counts settle.
  task automatic t_ratio(logic rx, int ch);
    dmdc_pkg::dmdc_counts_t e;
    logic [7:0]             c0;
    int                     n;
    sel.rx_mode = rx;
    sel.channel = 6'(ch);
    e = exp_of(rx, ch);
    c0 = cycles;
    n = 0;
    while (8'(cycles - c0) < 8'h3 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n == 20000) begin
      fails++;
      summarize;
    end
    check("ratio", ratio, 16'(e.coarse) * 16'h14 + 16'(e.fine));
    check("mod_after_load", modulus_high, 1'b0);
  endtask
  // Pulls reset in mid-run and checks the idle state while it is held.
  task automatic t_reset;
    sel.rx_mode = 1'b1;
    sel.channel = 6'h05;
    repeat (700) @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check("mid_rst_mod", modulus_high, 1'b0);
    check("mid_rst_load", load_n, 1'b1);
    check("mid_rst_counts", counts, {9'h10D, 5'h0D});
    rst = 1'b0;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    check("rst_mod", modulus_high, 1'b0);
    check("rst_load", load_n, 1'b1);
    check("rst_counts", counts, {9'h10D, 5'h0D});
    rst = 1'b0;
    t_table;
    t_ratio(1'b0, 1);
    t_ratio(1'b1, 1);
    t_ratio(1'b0, 23);
    t_ratio(1'b1, 12);
    t_reset;
    t_ratio(1'b1, 5);
    summarize;
  end
endmodule
